// [verilog/pcs_pkg.sv]
// Constants and types shared by the auxiliary port and its address decoders.
package pcs_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int PCS_PINS = 4;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] PCS_ADDR_LATCH  = 8'ha5;
    localparam logic [7:0] PCS_ADDR_CTRL_A = 8'ha2;
    localparam logic [7:0] PCS_ADDR_CTRL_B = 8'ha3;
    // Base pairs: low byte at base + 2*pin, high byte at base + 2*pin + 1.
    localparam logic [7:0] PCS_ADDR_BASE   = 8'hd0;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int         PCS_MODE_LSB    = 0;
    localparam int         PCS_SIZE_W      = 2;
    localparam logic [3:0] PCS_LATCH_RST   = 4'hf;
    localparam logic [7:0] PCS_CTRL_RST    = 8'h00;
    localparam logic [15:0] PCS_BASE_RST   = 16'h0000;

    // Address bits ignored for each range size code: 1, 16, 256, 4096 bytes.
    localparam logic [15:0] PCS_MASK_0 = 16'h0000;
    localparam logic [15:0] PCS_MASK_1 = 16'h000f;
    localparam logic [15:0] PCS_MASK_2 = 16'h00ff;
    localparam logic [15:0] PCS_MASK_3 = 16'h0fff;

    // ------------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PCS_MODE_IO = 2'b00,
        PCS_MODE_RD = 2'b01,
        PCS_MODE_WR = 2'b10,
        PCS_MODE_RW = 2'b11
    } pcs_mode_t;

endpackage : pcs_pkg

// [verilog/pcs_bus_if.sv]
// External bus address and strobes as seen by the per-pin decoders.
`timescale 1ns/100ps
interface pcs_bus_if;
    logic [15:0] addr;
    logic        rd_n;
    logic        wr_n;

    modport drv (output addr, output rd_n, output wr_n);
    modport dec (input addr, input rd_n, input wr_n);
endinterface : pcs_bus_if

// [verilog/pcs_decoder.sv]
// Address range match and strobe gating for one port pin.
`timescale 1ns/100ps
module pcs_decoder
(
    // External bus
    pcs_bus_if.dec                 bus,
    // Configuration
    input  wire pcs_pkg::pcs_mode_t i_mode,
    input  wire logic [15:0]       i_base,
    input  wire logic [1:0]        i_size,
    // Result
    output logic                   o_hit,
    output logic                   o_strobe_n
);

    logic [15:0] mask;

    always_comb
    begin
        case (i_size)
            2'h0:    mask = pcs_pkg::PCS_MASK_0;
            2'h1:    mask = pcs_pkg::PCS_MASK_1;
            2'h2:    mask = pcs_pkg::PCS_MASK_2;
            default: mask = pcs_pkg::PCS_MASK_3;
        endcase
    end

    assign o_hit = ((bus.addr & ~mask) == (i_base & ~mask));

    always_comb
    begin
        case (i_mode)
            pcs_pkg::PCS_MODE_RD: o_strobe_n = bus.rd_n | ~o_hit;
            pcs_pkg::PCS_MODE_WR: o_strobe_n = bus.wr_n | ~o_hit;
            pcs_pkg::PCS_MODE_RW: o_strobe_n = (bus.rd_n & bus.wr_n) | ~o_hit;
            default:              o_strobe_n = 1'b1;
        endcase
    end

endmodule : pcs_decoder

// [verilog/pcs_port.sv]
// Four-pin auxiliary port with general I/O and address-decoded strobe modes.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps

module pcs_port
(
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_nrst,
    // Register port
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_we,
    input  wire logic        i_reg_re,
    output logic      [7:0]  o_reg_rdata,
    // External bus from the core
    input  wire logic [15:0] i_bus_addr,
    input  wire logic        i_bus_rd_n,
    input  wire logic        i_bus_wr_n,
    // Port pins
    input  wire logic [3:0]  i_pin_in,
    output logic      [3:0]  o_pin_out,
    output logic      [3:0]  o_pin_oe_n
);

    localparam int N = pcs_pkg::PCS_PINS;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [N-1:0]        latch;
        logic [7:0]          ctrl_a;
        logic [7:0]          ctrl_b;
        logic [N-1:0][15:0]  base;
        logic [7:0]          rdata;
        logic [N-1:0]        pin_out;
        logic [N-1:0]        pin_oe_n;
        logic [N-1:0]        sync1;
        logic [N-1:0]        sync2;
    } pcs_state_t;

    pcs_state_t         st_q;
    pcs_state_t         st_d;
    pcs_pkg::pcs_mode_t mode;
    logic [N-1:0]       hit;
    logic [N-1:0]       strobe_n;

    assign mode = pcs_pkg::pcs_mode_t'(st_q.ctrl_a[pcs_pkg::PCS_MODE_LSB +: 2]);

    // ------------------------------------------------------------------
    // Per-pin decoders
    // ------------------------------------------------------------------
    pcs_bus_if bus_if ();

    assign bus_if.addr = i_bus_addr;
    assign bus_if.rd_n = i_bus_rd_n;
    assign bus_if.wr_n = i_bus_wr_n;

    generate
        for (genvar g = 0; g < N; g++)
        begin : g_pin
            pcs_decoder u_dec
            (
                .bus        (bus_if.dec),
                .i_mode     (mode),
                .i_base     (st_q.base[g]),
                .i_size     (st_q.ctrl_b[g*pcs_pkg::PCS_SIZE_W +: pcs_pkg::PCS_SIZE_W]),
                .o_hit      (hit[g]),
                .o_strobe_n (strobe_n[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        st_d       = st_q;
        st_d.sync1 = i_pin_in;
        st_d.sync2 = st_q.sync1;
        st_d.rdata = 8'h00;

        if (i_reg_we)
        begin
            if (i_reg_addr == pcs_pkg::PCS_ADDR_LATCH)
            begin
                st_d.latch = i_reg_wdata[N-1:0];
            end
            else if (i_reg_addr == pcs_pkg::PCS_ADDR_CTRL_A)
            begin
                st_d.ctrl_a = i_reg_wdata;
            end
            else if (i_reg_addr == pcs_pkg::PCS_ADDR_CTRL_B)
            begin
                st_d.ctrl_b = i_reg_wdata;
            end
            else if (i_reg_addr[7:3] == pcs_pkg::PCS_ADDR_BASE[7:3])
            begin
                if (i_reg_addr[0])
                begin
                    st_d.base[i_reg_addr[2:1]][15:8] = i_reg_wdata;
                end
                else
                begin
                    st_d.base[i_reg_addr[2:1]][7:0] = i_reg_wdata;
                end
            end
        end

        if (i_reg_re)
        begin
            if (i_reg_addr == pcs_pkg::PCS_ADDR_LATCH)
            begin
                // Like a general port, a read returns the pin levels.
                st_d.rdata = {4'h0, st_q.sync2};
            end
            else if (i_reg_addr == pcs_pkg::PCS_ADDR_CTRL_A)
            begin
                st_d.rdata = st_q.ctrl_a;
            end
            else if (i_reg_addr == pcs_pkg::PCS_ADDR_CTRL_B)
            begin
                st_d.rdata = st_q.ctrl_b;
            end
            else if (i_reg_addr[7:3] == pcs_pkg::PCS_ADDR_BASE[7:3])
            begin
                if (i_reg_addr[0])
                begin
                    st_d.rdata = st_q.base[i_reg_addr[2:1]][15:8];
                end
                else
                begin
                    st_d.rdata = st_q.base[i_reg_addr[2:1]][7:0];
                end
            end
        end

        if (mode == pcs_pkg::PCS_MODE_IO)
        begin
            // A one is released to the pull-up, a zero is driven low.
            st_d.pin_out  = st_q.latch;
            st_d.pin_oe_n = st_q.latch;
        end
        else
        begin
            st_d.pin_out  = strobe_n;
            st_d.pin_oe_n = '0;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            st_q          <= '0;
            st_q.latch    <= pcs_pkg::PCS_LATCH_RST;
            st_q.ctrl_a   <= pcs_pkg::PCS_CTRL_RST;
            st_q.ctrl_b   <= pcs_pkg::PCS_CTRL_RST;
            st_q.base     <= {N{pcs_pkg::PCS_BASE_RST}};
            st_q.pin_out  <= '1;
            st_q.pin_oe_n <= '1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign o_reg_rdata = st_q.rdata;
    assign o_pin_out   = st_q.pin_out;
    assign o_pin_oe_n  = st_q.pin_oe_n;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    AST_LATCH_WRITE: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_reg_we && i_reg_addr == pcs_pkg::PCS_ADDR_LATCH && mode == pcs_pkg::PCS_MODE_IO)
        |=> ##1 (o_pin_oe_n == $past(i_reg_wdata[3:0], 2) && o_pin_out == $past(i_reg_wdata[3:0], 2)))
        else $error("port latch write did not reach the pins");

    AST_IO_MODE: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (mode == pcs_pkg::PCS_MODE_IO) |=> (o_pin_out == $past(st_q.latch) && o_pin_oe_n == o_pin_out))
        else $error("general I/O mode pins do not follow the latch");

    AST_RD_STROBE: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (mode == pcs_pkg::PCS_MODE_RD && !i_bus_rd_n && hit[0]) |=> !o_pin_out[0])
        else $error("read strobe missing on pin 0");

    AST_WR_STROBE: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (mode == pcs_pkg::PCS_MODE_WR && i_bus_wr_n) |=> o_pin_out == 4'hf)
        else $error("write strobe active without bus write");

    AST_RW_STROBE: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (mode == pcs_pkg::PCS_MODE_RW && hit[1] && !(i_bus_rd_n && i_bus_wr_n)) |=> !o_pin_out[1])
        else $error("read/write strobe missing on pin 1");

    AST_BASE_READ: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_reg_re && i_reg_addr == pcs_pkg::PCS_ADDR_BASE) |=> (o_reg_rdata == $past(st_q.base[0][7:0])))
        else $error("base low byte of pin 0 read back wrong");

    AST_RDATA_IDLE: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        !i_reg_re |=> (o_reg_rdata == 8'h00))
        else $error("read data present without a read");

    AST_STROBE_DRIVE: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (mode != pcs_pkg::PCS_MODE_IO) |=> (o_pin_oe_n == 4'h0))
        else $error("strobe pins not actively driven");

    AST_IDLE_HIGH: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (mode != pcs_pkg::PCS_MODE_IO && hit == '0) |=> (o_pin_out == 4'hf))
        else $error("strobe active outside its range");

    COV_RD:  cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
        mode == pcs_pkg::PCS_MODE_RD && !i_bus_rd_n && hit[0]);
    COV_WR:  cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
        mode == pcs_pkg::PCS_MODE_WR && !i_bus_wr_n && hit[2]);
    COV_RW:  cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
        mode == pcs_pkg::PCS_MODE_RW && !i_bus_wr_n && hit[3]);
    COV_PIN: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
        mode == pcs_pkg::PCS_MODE_IO && st_q.latch != 4'hf);

endmodule : pcs_port

// [bench/pcs_periph.sv]
// Peripheral side of the four port pins: pull-ups and an open-drain pull-down.
`timescale 1ns/100ps
module pcs_periph
(
    // Port pins as driven by the block
    input  wire logic [3:0] i_pin_out,
    input  wire logic [3:0] i_pin_oe_n,
    // Pins that the peripheral pulls low while released
    input  wire logic [3:0] i_pull_low,
    // Resolved wire level
    output logic      [3:0] o_wire
);
    // A released pin rests high on its pull-up unless the peripheral sinks it.
    assign o_wire = (~i_pin_oe_n & i_pin_out) | (i_pin_oe_n & ~i_pull_low);
endmodule : pcs_periph

// [bench/pcs_port_bench.sv]
// Self-checking bench for the auxiliary port: registers, I/O mode and strobe modes.
`timescale 1ns/100ps
module pcs_port_bench;
    // ------------------------------------------------------------------
    // Stimulus and observation
    // ------------------------------------------------------------------
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  ra = 8'h00;
    logic [7:0]  wd = 8'h00;
    logic        we = 1'b0;
    logic        re = 1'b0;
    logic [7:0]  rd;
    logic [15:0] ba = 16'h0000;
    logic        brd_n = 1'b1;
    logic        bwr_n = 1'b1;
    logic [3:0]  pull = 4'h0;
    logic [3:0]  lvl;
    logic [3:0]  pout;
    logic [3:0]  poe_n;
    int          err_count = 0;
    int          total_checks = 0;
    logic [15:0] base [4] = '{16'h1234, 16'h2340, 16'h3400, 16'h4000};
    logic [15:0] msk [4] = '{pcs_pkg::PCS_MASK_0, pcs_pkg::PCS_MASK_1, pcs_pkg::PCS_MASK_2, pcs_pkg::PCS_MASK_3};

    always #12.5 clk = ~clk;

    pcs_port pcs_port_i (.i_ref_clk(clk), .i_nrst(nrst), .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_we(we),
        .i_reg_re(re), .o_reg_rdata(rd), .i_bus_addr(ba), .i_bus_rd_n(brd_n), .i_bus_wr_n(bwr_n),
        .i_pin_in(lvl), .o_pin_out(pout), .o_pin_oe_n(poe_n));
    pcs_periph pcs_periph_i (.i_pin_out(pout), .i_pin_oe_n(poe_n), .i_pull_low(pull), .o_wire(lvl));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        total_checks++;
        if (rd !== exp)
        begin
            err_count++;
            $display("unexpected rdata at %h: expected %h, seen %h", a, exp, rd);
        end
    endtask : chk_reg

    task automatic chk_pin(input logic [3:0] eo, input logic [3:0] eoe);
        total_checks++;
        if (pout !== eo || poe_n !== eoe)
        begin
            err_count++;
            $display("unexpected pins: expected %h/%h, seen %h/%h", eo, eoe, pout, poe_n);
        end
    endtask : chk_pin

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        ra <= a;
        wd <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        ra <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 chk_reg(a, exp);
    endtask : reg_rd

    task automatic bus(input logic [15:0] a, input logic r_n, input logic w_n, input logic [3:0] eo,
                       input logic [3:0] eoe);
        @(posedge clk);
        ba <= a;
        brd_n <= r_n;
        bwr_n <= w_n;
        repeat (2) @(posedge clk);
        #1 chk_pin(eo, eoe);
    endtask : bus

    function automatic logic [3:0] exp_pin(int m, int k, int x, bit hit);
        if (m == 0)
            return 4'h5;
        return (hit && (m & k) != 0) ? ~(4'h1 << x) : 4'hf;
    endfunction : exp_pin

    task automatic summarize;
        $display("checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        #(25 * 4000);
        err_count++;
        summarize();
    end

    initial
    begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        #1 chk_pin(4'hf, 4'hf);
        reg_rd(pcs_pkg::PCS_ADDR_CTRL_A, 8'h00);
        reg_rd(pcs_pkg::PCS_ADDR_CTRL_B, 8'h00);
        reg_rd(8'hd7, 8'h00);
        reg_rd(pcs_pkg::PCS_ADDR_LATCH, 8'h0f);
        reg_rd(8'h44, 8'h00);
        $display("test reset done");
        reg_wr(pcs_pkg::PCS_ADDR_CTRL_B, 8'he4);
        for (int x = 0; x < 4; x++)
        begin
            reg_wr(8'(pcs_pkg::PCS_ADDR_BASE + 2 * x), base[x][7:0]);
            reg_wr(8'(pcs_pkg::PCS_ADDR_BASE + 2 * x + 1), base[x][15:8]);
        end
        reg_rd(8'hd6, 8'h00);
        reg_rd(8'hd3, 8'h23);
        reg_rd(pcs_pkg::PCS_ADDR_BASE, 8'h34);
        reg_rd(pcs_pkg::PCS_ADDR_CTRL_B, 8'he4);
        reg_wr(pcs_pkg::PCS_ADDR_LATCH, 8'h05);
        pull <= 4'h4;
        repeat (4) @(posedge clk);
        #1 chk_pin(4'h5, 4'h5);
        reg_rd(pcs_pkg::PCS_ADDR_LATCH, 8'h01);
        @(posedge clk);
        pull <= 4'h0;
        $display("test io done");
        for (int m = 0; m < 4; m++)
        begin
            reg_wr(pcs_pkg::PCS_ADDR_CTRL_A, 8'(m));
            for (int k = 1; k < 3; k++)
                for (int x = 0; x < 4; x++)
                begin
                    bus(base[x] | msk[x], k != 1, k != 2, exp_pin(m, k, x, 1'b1), (m == 0) ? 4'h5 : 4'h0);
                    bus(base[x] + msk[x] + 16'h0001, k != 1, k != 2, exp_pin(m, k, x, 1'b0),
                        (m == 0) ? 4'h5 : 4'h0);
                    bus(base[x], 1'b1, 1'b1, exp_pin(m, k, x, 1'b0), (m == 0) ? 4'h5 : 4'h0);
                end
            $display("test mode %0d done", m);
        end
        summarize();
    end
endmodule : pcs_port_bench
